/* common/power_save_pkg.sv */
// Package for the power-save mode controller: registers, fields, states
package power_save_pkg;
    // Register byte addresses
    localparam logic [7:0] CLOCK_DIV_ADDR  = 8'h00;
    localparam logic [7:0] RESET_CTRL_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR     = 8'h08;
    localparam logic [7:0] CONTROL_ADDR    = 8'h0C;
    localparam logic [7:0] STOP_IDLE_ADDR  = 8'h10;
    // Clock divisor fields
    localparam int RATIO_LSB   = 12;
    localparam int RATIO_W     = 3;
    localparam int REDUCE_EN_B = 11;
    localparam int ROI_B       = 15;
    localparam logic [RATIO_W-1:0] RATIO_ZERO = 3'h0;
    // Reset control fields
    localparam int CORE_REG_B  = 8;
    localparam int FLASH_REG_B = 11;
    // Control register fields
    localparam int WDT_EN_B    = 0;
    localparam int FAIL_SAFE_CLOCK_MONITOR_EN_B   = 1;
    localparam int ONCHIP_B    = 2;
    // Idle resume delay in clock cycles, within the 2 to 4 window
    localparam logic [2:0] IDLE_RESUME_CYC = 3'h3;
    localparam logic [2:0] CNT_ONE         = 3'h1;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_RUN, ST_ENTER_SLEEP, ST_SLEEP, ST_ENTER_IDLE, ST_IDLE, ST_RESUME
    } pwr_state_t;

    // Power-save request from the CPU
    typedef struct packed {
        logic req;
        logic idle;
    } save_req_t;

    // Clock and regulator controls to the clock tree
    typedef struct packed {
        logic sys_clk_en;
        logic osc_en;
        logic cpu_clk_en;
        logic low_power_rc_clock_en;
        logic fail_safe_clock_monitor_active;
        logic core_reg_on;
        logic flash_reg_on;
    } clk_ctrl_t;
endpackage : power_save_pkg

/* src/power_save_mode_controller.sv */
// Power-save mode controller: Sleep, Idle, clock reduction interlocks
// Functional notes
// - Ratio field writes ignored while the reduction enable is set.
// - Recover-on-interrupt plus interrupt clears the reduction enable.
// - Setting reduction enable ignored while ratio is zero.
// - Sleep stops system clock; on-chip oscillator is turned off when the on-chip bit is set.
// - Fail-safe clock monitor inactive during Sleep.
// - Low-power RC clock runs in Sleep when watchdog enabled.
// - Watchdog counter cleared in the first Sleep cycle, when the watchdog is enabled.
// - System-clocked peripherals disabled in Sleep; external ones may run.
// - Sleep exits on enabled interrupt, any reset, or watchdog time-out.
// - CPU resumes on the clock source selected at Sleep entry.
// - Bits 8 and 11 keep core and flash regulators on in Sleep.
// - Idle stops the CPU and clears the watchdog counter.
// - Idle keeps system clock; peripherals run unless stopped.
// - Low-power RC runs in Idle when watchdog or monitor enabled.
// - Idle exits on enabled interrupt, any reset, or watchdog time-out.
// - Idle wake resumes CPU after a fixed delay of 2-4 cycles.
// - Each peripheral has a stop-in-Idle bit halting it in Idle.
// - Interrupt during the power-save instruction is held, then wakes.
`timescale 1ns/10ps
module power_save_mode_controller
    import power_save_pkg::*;
#(
    parameter int N_PERIPH = 8,
    parameter int CLK_SEL_W = 3
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // CPU side
    input  wire save_req_t            save_req_i,
    input  wire logic                 irq_pending_i,
    input  wire logic                 wdt_timeout_i,
    input  wire logic [CLK_SEL_W-1:0] clk_sel_i,
    output logic                      wdt_clear_o,
    output logic                      cpu_stall_o,
    output logic                      irq_wake_o,
    output logic [CLK_SEL_W-1:0]      resume_clk_sel_o,
    output logic [RATIO_W-1:0]        cpu_clock_reduce_ratio_o,
    output logic                      cpu_clock_reduce_enable_o,
    output clk_ctrl_t                 clk_ctrl_o,
    output logic [N_PERIPH-1:0]       periph_clk_en_o
);

    pwr_state_t               state_r;
    logic [RATIO_W-1:0]       ratio_r;
    logic                     reduce_en_r;
    logic                     roi_r;
    logic                     core_keep_r;
    logic                     flash_keep_r;
    logic                     wdt_en_r;
    logic                     fail_safe_clock_monitor_en_r;
    logic                     onchip_r;
    logic [N_PERIPH-1:0]      stop_idle_r;
    logic                     held_irq_r;
    logic [2:0]               resume_cnt_r;
    logic [CLK_SEL_W-1:0]     sleep_clk_r;
    logic                     wdt_clear_r;
    logic                     ack_r;
    logic [31:0]              rdata_r;
    logic                     wr_stb;
    logic                     in_sleep;
    logic                     in_idle;
    logic                     wake;

    assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign in_sleep = (state_r == ST_SLEEP);
    assign in_idle  = (state_r == ST_IDLE);
    assign wake     = irq_pending_i || held_irq_r || wdt_timeout_i;

    // Power-state sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else if (ce_i) begin
            case (state_r)
                ST_RUN: begin
                    if (save_req_i.req) begin
                        state_r <= save_req_i.idle ? ST_ENTER_IDLE
                                                   : ST_ENTER_SLEEP;
                    end
                end
                ST_ENTER_SLEEP: state_r <= ST_SLEEP;
                ST_ENTER_IDLE:  state_r <= ST_IDLE;
                ST_SLEEP: begin
                    if (wake) begin
                        state_r <= ST_RESUME;
                    end
                end
                ST_IDLE: begin
                    if (wake) begin
                        state_r <= ST_RESUME;
                    end
                end
                ST_RESUME: begin
                    if (resume_cnt_r == CNT_ONE) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // Resume delay counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resume_cnt_r <= 3'h0;
        end else if (ce_i) begin
            if ((in_sleep || in_idle) && wake) begin
                resume_cnt_r <= IDLE_RESUME_CYC;
            end else if (state_r == ST_RESUME) begin
                resume_cnt_r <= resume_cnt_r - CNT_ONE;
            end
        end
    end

    // Interrupt coincident with entry is held until entry completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_irq_r <= 1'b0;
        end else if (ce_i) begin
            if ((state_r == ST_RUN && save_req_i.req && irq_pending_i) ||
                ((state_r == ST_ENTER_SLEEP || state_r == ST_ENTER_IDLE)
                 && irq_pending_i)) begin
                held_irq_r <= 1'b1;
            end else if (in_sleep || in_idle) begin
                held_irq_r <= 1'b0;
            end
        end
    end

    // Watchdog clear pulse on Idle entry, and on Sleep entry when the watchdog is enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_r <= 1'b0;
        end else if (ce_i) begin
            wdt_clear_r <= (state_r == ST_ENTER_SLEEP && wdt_en_r)
                        || (state_r == ST_ENTER_IDLE);
        end
    end

    // Clock source remembered at Sleep entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_clk_r <= '0;
        end else if (ce_i) begin
            if (state_r == ST_RUN) begin
                sleep_clk_r <= clk_sel_i;
            end
        end
    end

    // Clock divisor register with write interlocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_r     <= RATIO_ZERO;
            reduce_en_r <= 1'b0;
            roi_r       <= 1'b0;
        end else if (ce_i) begin
            if (wr_stb && wb_adr_i == CLOCK_DIV_ADDR && wb_sel_i[1]) begin
                if (!reduce_en_r && wb_sel_i[1]) begin
                    ratio_r <= wb_dat_i[RATIO_LSB +: RATIO_W];
                end
                roi_r <= wb_dat_i[ROI_B];
                if (!wb_dat_i[REDUCE_EN_B]) begin
                    reduce_en_r <= 1'b0;
                end else if (ratio_r != RATIO_ZERO) begin
                    reduce_en_r <= 1'b1;
                end
            end
            if (roi_r && irq_pending_i) begin
                reduce_en_r <= 1'b0;
            end
        end
    end

    // Reset control, control and stop-in-Idle registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_keep_r  <= 1'b0;
            flash_keep_r <= 1'b0;
            wdt_en_r     <= 1'b0;
            fail_safe_clock_monitor_en_r    <= 1'b0;
            onchip_r     <= 1'b1;
            stop_idle_r  <= '0;
        end else if (ce_i && wr_stb) begin
            if (wb_adr_i == RESET_CTRL_ADDR && wb_sel_i[1]) begin
                core_keep_r  <= wb_dat_i[CORE_REG_B];
                flash_keep_r <= wb_dat_i[FLASH_REG_B];
            end
            if (wb_adr_i == CONTROL_ADDR && wb_sel_i[0]) begin
                wdt_en_r  <= wb_dat_i[WDT_EN_B];
                fail_safe_clock_monitor_en_r <= wb_dat_i[FAIL_SAFE_CLOCK_MONITOR_EN_B];
                onchip_r  <= wb_dat_i[ONCHIP_B];
            end
            if (wb_adr_i == STOP_IDLE_ADDR) begin
                stop_idle_r <= wb_dat_i[N_PERIPH-1:0];
            end
        end
    end

    // Wishbone ack and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= WORD_ZERO;
        end else if (ce_i) begin
            ack_r   <= wb_cyc_i && wb_stb_i && !ack_r;
            rdata_r <= WORD_ZERO;
            case (wb_adr_i)
                CLOCK_DIV_ADDR: begin
                    rdata_r[ROI_B]                  <= roi_r;
                    rdata_r[RATIO_LSB +: RATIO_W]   <= ratio_r;
                    rdata_r[REDUCE_EN_B]            <= reduce_en_r;
                end
                RESET_CTRL_ADDR: begin
                    rdata_r[CORE_REG_B]  <= core_keep_r;
                    rdata_r[FLASH_REG_B] <= flash_keep_r;
                end
                STATUS_ADDR: rdata_r[2:0] <= state_r;
                CONTROL_ADDR: begin
                    rdata_r[WDT_EN_B]  <= wdt_en_r;
                    rdata_r[FAIL_SAFE_CLOCK_MONITOR_EN_B] <= fail_safe_clock_monitor_en_r;
                    rdata_r[ONCHIP_B]  <= onchip_r;
                end
                STOP_IDLE_ADDR: rdata_r[N_PERIPH-1:0] <= stop_idle_r;
                default: rdata_r <= WORD_ZERO;
            endcase
        end
    end

    // Clock tree controls
    always_comb begin
        clk_ctrl_o.sys_clk_en   = !in_sleep;
        clk_ctrl_o.osc_en       = !(in_sleep && onchip_r);
        clk_ctrl_o.cpu_clk_en   = (state_r == ST_RUN);
        clk_ctrl_o.low_power_rc_clock_en      = in_sleep ? wdt_en_r
                                : (wdt_en_r || fail_safe_clock_monitor_en_r);
        clk_ctrl_o.fail_safe_clock_monitor_active  = fail_safe_clock_monitor_en_r && !in_sleep;
        clk_ctrl_o.core_reg_on  = !in_sleep || core_keep_r;
        clk_ctrl_o.flash_reg_on = !in_sleep || flash_keep_r;
    end

    // Per-peripheral clock enables
    for (genvar g = 0; g < N_PERIPH; g++) begin : g_periph
        assign periph_clk_en_o[g] = !in_sleep
                                 && !(in_idle && stop_idle_r[g]);
    end

    assign wb_ack_o                  = ack_r;
    assign wb_dat_o                  = rdata_r;
    assign wdt_clear_o               = wdt_clear_r;
    assign cpu_stall_o               = (state_r != ST_RUN);
    assign irq_wake_o                = (in_sleep || in_idle) && wake;
    assign resume_clk_sel_o          = sleep_clk_r;
    assign cpu_clock_reduce_ratio_o  = ratio_r;
    assign cpu_clock_reduce_enable_o = reduce_en_r;

endmodule : power_save_mode_controller

/* test/power_save_assertions.sv */
// Port-level checks for the power-save mode controller
`timescale 1ns/10ps
module power_save_assertions
    import power_save_pkg::*;
#(
    parameter int N_PERIPH  = 8,
    parameter int CLK_SEL_W = 3
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire save_req_t            save_req_i,
    input wire logic [CLK_SEL_W-1:0] clk_sel_i,
    input wire logic                 wb_ack_o,
    input wire logic                 wdt_clear_o,
    input wire logic                 cpu_stall_o,
    input wire logic                 irq_wake_o,
    input wire logic [CLK_SEL_W-1:0] resume_clk_sel_o,
    input wire logic [RATIO_W-1:0]   cpu_clock_reduce_ratio_o,
    input wire logic                 cpu_clock_reduce_enable_o,
    input wire clk_ctrl_t            clk_ctrl_o,
    input wire logic [N_PERIPH-1:0]  periph_clk_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic run_req;
    // Request taken while running
    assign run_req = ce_i && save_req_i.req && !cpu_stall_o;
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ratio_lock_a: assert property (
        cpu_clock_reduce_enable_o |=> $stable(cpu_clock_reduce_ratio_o))
        else $error("ratio changed while reduction enabled");
    zero_ratio_a: assert property (
        !cpu_clock_reduce_enable_o && cpu_clock_reduce_ratio_o == RATIO_ZERO
        |=> !cpu_clock_reduce_enable_o) else $error("enable set at ratio 0");
    sleep_entry_a: assert property (
        run_req && !save_req_i.idle |=> cpu_stall_o ##1
        !clk_ctrl_o.sys_clk_en) else $error("sleep not entered");
    idle_entry_a: assert property (
        run_req && save_req_i.idle |=> cpu_stall_o ##1 (wdt_clear_o &&
        clk_ctrl_o.sys_clk_en && !clk_ctrl_o.cpu_clk_en))
        else $error("idle entry wrong");
    sleep_off_a: assert property (
        !clk_ctrl_o.sys_clk_en |-> !clk_ctrl_o.fail_safe_clock_monitor_active &&
        !clk_ctrl_o.cpu_clk_en && periph_clk_en_o == '0)
        else $error("logic active in sleep");
    sleep_low_power_rc_clock_a: assert property (
        !clk_ctrl_o.sys_clk_en && wdt_clear_o |-> clk_ctrl_o.low_power_rc_clock_en)
        else $error("rc clock off with watchdog on");
    wake_delay_a: assert property (
        irq_wake_o |=> cpu_stall_o [*3] ##1 !cpu_stall_o)
        else $error("resume delay wrong");
    clk_keep_a: assert property (
        $rose(cpu_stall_o) |-> resume_clk_sel_o == $past(clk_sel_i))
        else $error("resume source not captured");
    cover property (run_req && save_req_i.idle);
    cover property (run_req && !save_req_i.idle);
    cover property (irq_wake_o);
endmodule : power_save_assertions
bind power_save_mode_controller power_save_assertions #(
    .N_PERIPH(N_PERIPH), .CLK_SEL_W(CLK_SEL_W)) power_save_assertions_inst (
    .clk_i, .rst_i, .ce_i, .save_req_i, .clk_sel_i, .wb_ack_o,
    .wdt_clear_o, .cpu_stall_o, .irq_wake_o, .resume_clk_sel_o,
    .cpu_clock_reduce_ratio_o, .cpu_clock_reduce_enable_o, .clk_ctrl_o,
    .periph_clk_en_o);

/* test/cpu_model.sv */
// Behavioural CPU core and interrupt source beside the controller
`timescale 1ns/10ps
module cpu_model
    import power_save_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic go_i,
    input  wire logic idle_i,
    input  wire logic irq_set_i,
    input  wire logic cpu_stall_i,
    output save_req_t save_req_o = '0,
    output logic      irq_o = 1'b0
);
    // One-cycle power-save request naming the wanted mode
    always @(posedge clk_i) begin
        save_req_o.req  <= go_i && !cpu_stall_i && !rst_i;
        save_req_o.idle <= idle_i;
    end
    // Interrupt stays pending until the core runs and services it
    always @(posedge clk_i) begin
        if (rst_i || (!cpu_stall_i && !irq_set_i)) begin
            irq_o <= 1'b0;
        end else if (irq_set_i) begin
            irq_o <= 1'b1;
        end
    end
endmodule : cpu_model

/* test/tb_top.sv */
// Self-checking bench for the power-save mode controller
`timescale 1ns/10ps
module tb_top;
    import power_save_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic go = 1'b0, idle = 1'b0, irq_set = 1'b0, wdt_to = 1'b0, ack;
    logic stall, irq, en;
    logic [7:0] adr = 8'h00, pen;
    logic [31:0] dat = 32'h0, rdat;
    logic [2:0] src = 3'h0, rsel, ratio;
    save_req_t req;
    clk_ctrl_t cc;
    int err_count = 0, comparisons = 0;
    always #2 clk_i = ~clk_i;
    power_save_mode_controller #(.N_PERIPH(8), .CLK_SEL_W(3))
        power_save_mode_controller_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .save_req_i(req),
        .irq_pending_i(irq), .wdt_timeout_i(wdt_to), .clk_sel_i(src),
        .wdt_clear_o(), .cpu_stall_o(stall), .irq_wake_o(),
        .resume_clk_sel_o(rsel), .cpu_clock_reduce_ratio_o(ratio),
        .cpu_clock_reduce_enable_o(en), .clk_ctrl_o(cc),
        .periph_clk_en_o(pen));
    cpu_model cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .idle_i(idle), .irq_set_i(irq_set), .cpu_stall_i(stall),
        .save_req_o(req), .irq_o(irq));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Classic cycle, held until ack is seen at a rising edge
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask : rd
    // Power-save instruction, optionally with a coincident interrupt
    task automatic save(input logic i, input logic q);
        go <= 1'b1;
        idle <= i;
        irq_set <= q;
        @(posedge clk_i);
        go <= 1'b0;
        irq_set <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : save
    // Raise a wake cause and count cycles until the core runs
    task automatic wake(input logic i, input logic w, input int e);
        int n;
        irq_set <= i;
        wdt_to <= w;
        @(posedge clk_i);
        irq_set <= 1'b0;
        wdt_to <= 1'b0;
        n = 1;
        while (stall !== 1'b0 && n < 12) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n), 32'(e));
    endtask : wake
    task automatic summarize();
        $display("err_count %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(CONTROL_ADDR, 32'h0000_0004);
        rd(RESET_CTRL_ADDR, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        wr(CLOCK_DIV_ADDR, 32'h0000_0800);
        rd(CLOCK_DIV_ADDR, 32'h0000_0000);
        wr(CLOCK_DIV_ADDR, 32'h0000_5000);
        wr(CLOCK_DIV_ADDR, 32'h0000_D800);
        wr(CLOCK_DIV_ADDR, 32'h0000_A800);
        rd(CLOCK_DIV_ADDR, 32'h0000_D800);
        chk(32'(ratio), 32'h5);
        wake(1'b1, 1'b0, 1);
        @(posedge clk_i);
        rd(CLOCK_DIV_ADDR, 32'h0000_D000);
        wr(RESET_CTRL_ADDR, 32'h0000_0900);
        rd(RESET_CTRL_ADDR, 32'h0000_0900);
        wr(CONTROL_ADDR, 32'h0000_0005);
        wr(STOP_IDLE_ADDR, 32'h0000_000F);
        src <= 3'h6;
        save(1'b0, 1'b0);
        src <= 3'h1;
        rd(STATUS_ADDR, 32'h0000_0002);
        chk(32'(cc), 32'h0B);
        chk(32'(pen), 32'h0);
        chk(32'(rsel), 32'h6);
        wake(1'b0, 1'b1, 5);
        wr(CONTROL_ADDR, 32'h0000_0002);
        save(1'b1, 1'b0);
        chk(32'(pen), 32'hF0);
        chk(32'(cc[6:3]), 32'hD);
        wake(1'b1, 1'b0, 6);
        save(1'b1, 1'b1);
        wake(1'b0, 1'b0, 4);
        summarize();
    end
endmodule : tb_top
